// [verilog/gauge_i2c_pkg.sv]
// Shared constants and types for the gauge I2C target port and its master
package gauge_i2c_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 25;

  localparam logic [6:0] DEV_ADDR = 7'h55;
  localparam logic [7:0] ADDR_WR_BYTE = 8'hAA;
  localparam logic [7:0] ADDR_RD_BYTE = 8'hAB;
  localparam logic [7:0] MAX_CMD = 8'h6B;
  localparam logic [7:0] PTR_RESET = 8'h00;

  localparam int BUS_TIMEOUT_MS = 2000;
  localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * CYC_PER_MS;
  localparam int STRETCH_MS = 80;
  localparam int STRETCH_CYC = STRETCH_MS * CYC_PER_MS;
  localparam int CHECKSUM_WAIT_MS = 100;
  localparam int CHECKSUM_WAIT_CYC = CHECKSUM_WAIT_MS * CYC_PER_MS;
  localparam int STD_RW_WAIT_MS = 2000;
  localparam int STD_RW_WAIT_CYC = STD_RW_WAIT_MS * CYC_PER_MS;
  localparam int STD_RATE_PER_S = 2;
  localparam int STD_SPACING_CYC = 1000 * CYC_PER_MS / STD_RATE_PER_S;
  localparam int SUBCMD_WAIT_US = 1000;
  localparam int SUBCMD_WAIT_CYC = (SUBCMD_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_GAP_NS = 66000;
  localparam int READ_GAP_CYC = (READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_HALF_NS = 1250;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] DATA_HOLD_CYC = 25'h0000002;
  localparam logic [2:0] SETTLE_CYC = 3'h7;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_ADDR = 4'h1, S_CMD = 4'h2, S_WDATA = 4'h3, S_RDATA = 4'h4,
    S_ACK = 4'h5, S_MACK = 4'h6, S_IGNORE = 4'h7, S_RELEASED = 4'h8, S_SLEEP = 4'h9
  } dev_state_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'h0, H_START = 4'h1, H_LOW = 4'h2, H_HIGH = 4'h3, H_RS_A = 4'h4,
    H_RS_B = 4'h5, H_STOP_A = 4'h6, H_STOP_B = 4'h7, H_GAP = 4'h8
  } host_state_t;

  typedef enum logic [2:0] {
    PH_ADDRW = 3'h0, PH_CMD = 3'h1, PH_WDATA = 3'h2, PH_ADDRR = 3'h3, PH_RDATA = 3'h4
  } phase_t;

  typedef enum logic [1:0] {OP_READ = 2'h0, OP_QUICK = 2'h1, OP_WRITE = 2'h2} op_t;

  typedef enum logic [2:0] {
    W_NONE = 3'h0, W_SUBCMD = 3'h1, W_CHECKSUM = 3'h2, W_STD_RW = 3'h3, W_STD_RO = 3'h4
  } wait_t;
endpackage

// [verilog/gauge_i2c_if.sv]
// Open-drain I2C wires joining the gauge target and its master
`timescale 1ns/1ps
interface gauge_i2c_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  // Driven by the bench to model a stuck line
  logic ext_scl_hold;
  logic ext_sda_hold;
  logic scl;
  logic sda;

  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o) | ext_scl_hold);
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o) | ext_sda_hold);

  modport dev (input scl, input sda,
    output dev_scl_o, output dev_scl_oe, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda,
    output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

// [verilog/gauge_i2c_target.sv]
// Gauge I2C target end: address match, pointer, stretch, bus timeout
// Notes on behaviour
// [RULE_01] Accept read, quick read, all write formats
// [RULE_02] Answer only address 1010101, bytes AA/AB
// [RULE_03] Quick read returns data at current pointer
// [RULE_04] Pointer advances on every acknowledged data byte
// [RULE_05] Write bytes land in consecutive locations
// [RULE_06] Write to read-only location gets NACK
// [RULE_07] Command above 6B gets NACK
// [RULE_08] Line low two seconds: release both lines
// [RULE_09] Still held low after release: sleep
// [RULE_10] Master waits after command at 400 kHz
// [RULE_11] Master waits 100 ms after checksum
// [RULE_12] Master waits 2 s after read-write command
// [RULE_13] Master sends standard commands twice per second
// [RULE_14] Too-fast commands trip the watchdog
// [RULE_15] Master leaves 66 us after stop
// [RULE_16] Clock stretch up to 80 ms, master tolerates
// [RULE_17] Command byte loads the pointer first
`timescale 1ns/1ps
module gauge_i2c_target
  import gauge_i2c_pkg::*;
#(
  parameter int TIMEOUT_CYC = BUS_TIMEOUT_CYC,
  parameter int STRETCH_MAX_CYC = STRETCH_CYC,
  parameter int WDOG_GAP_CYC = STD_SPACING_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus
  gauge_i2c_if.dev bus,
  // Command location access
  input wire logic [7:0] loc_rdata,
  input wire logic loc_read_only,
  input wire logic flash_busy,
  output logic [7:0] loc_ptr,
  output logic loc_wr_en,
  output logic [7:0] loc_wr_addr,
  output logic [7:0] loc_wr_data,
  // Status
  output logic bus_sleep,
  output logic wdog_trip
);
  localparam logic [CNT_W-1:0] TIMEOUT_LAST = CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [CNT_W-1:0] STRETCH_LAST = CNT_W'(STRETCH_MAX_CYC - 1);
  localparam logic [CNT_W-1:0] WDOG_SAT = CNT_W'(WDOG_GAP_CYC);

  typedef struct packed {
    dev_state_t st;
    dev_state_t after;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    logic [3:0] bits;
    logic [7:0] shr;
    logic mack;
    logic [7:0] ptr;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic sda_oe;
    logic stretch;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] str_cnt;
    logic [CNT_W-1:0] cmd_gap;
    logic [2:0] settle;
    logic sleep;
    logic wdog;
  } dev_regs_t;

  dev_regs_t r;
  dev_regs_t n;

  logic scl_h;
  logic sda_h;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic line_low;
  logic line_move;
  logic active;

  assign scl_h = r.scl_s[1];
  assign sda_h = r.sda_s[1];
  assign scl_rise = scl_h & ~r.scl_d;
  assign scl_fall = ~scl_h & r.scl_d;
  assign start_c = scl_h & r.scl_d & r.sda_d & ~sda_h;
  assign stop_c = scl_h & r.scl_d & ~r.sda_d & sda_h;
  assign line_low = ~scl_h | ~sda_h;
  assign line_move = (scl_h != r.scl_d) | (sda_h != r.sda_d);
  assign active = (r.st != S_IDLE) && (r.st != S_IGNORE) && (r.st != S_RELEASED)
    && (r.st != S_SLEEP);

  always_comb begin
    n = r;
    n.wr_en = 1'b0;
    n.wdog = 1'b0;
    // Only the second stage and the delayed copy feed any logic
    n.scl_s = {r.scl_s[0], bus.scl};
    n.sda_s = {r.sda_s[0], bus.sda};
    n.scl_d = r.scl_s[1];
    n.sda_d = r.sda_s[1];
    if (r.cmd_gap != WDOG_SAT) begin
      n.cmd_gap = r.cmd_gap + 25'h0000001;
    end

    // Hold SCL low after a falling edge while flash is being written
    if (r.stretch) begin
      n.str_cnt = r.str_cnt + 25'h0000001;
      if (!flash_busy || r.str_cnt == STRETCH_LAST) begin
        n.stretch = 1'b0; // RULE_16
      end
    end else if (scl_fall && flash_busy && active) begin
      n.stretch = 1'b1; // RULE_16
      n.str_cnt = '0;
    end

    case (r.st)
      S_IDLE: begin
      end
      S_ADDR, S_CMD, S_WDATA: begin
        if (scl_rise && r.bits < 4'h8) begin
          n.shr = {r.shr[6:0], sda_h};
          n.bits = r.bits + 4'h1;
        end
        if (scl_fall && r.bits == 4'h8) begin
          n.st = S_IGNORE;
          case (r.st)
            S_ADDR: begin
              if (r.shr[7:1] == DEV_ADDR) begin // RULE_02
                n.sda_oe = 1'b1;
                n.st = S_ACK;
                n.after = r.shr[0] ? S_RDATA : S_CMD; // RULE_01
              end
            end
            S_CMD: begin
              if (r.shr <= MAX_CMD) begin // RULE_07
                n.sda_oe = 1'b1;
                n.st = S_ACK;
                n.after = S_WDATA;
                n.ptr = r.shr; // RULE_17
                n.cmd_gap = '0;
                if (r.cmd_gap != WDOG_SAT) begin
                  n.wdog = 1'b1; // RULE_14
                end
              end
            end
            default: begin
              // Read-only target falls through to ignore, data not stored
              if (!loc_read_only) begin // RULE_06
                n.sda_oe = 1'b1;
                n.st = S_ACK;
                n.after = S_WDATA;
                n.wr_en = 1'b1; // RULE_05
                n.wr_addr = r.ptr;
                n.wr_data = r.shr;
                n.ptr = r.ptr + 8'h01; // RULE_04
              end
            end
          endcase
        end
      end
      S_ACK: begin
        if (scl_fall) begin
          n.sda_oe = 1'b0;
          n.bits = '0;
          n.st = r.after;
          if (r.after == S_RDATA) begin
            // Quick read lands here straight after the address
            n.shr = loc_rdata; // RULE_03
            n.sda_oe = ~loc_rdata[7];
          end
        end
      end
      S_RDATA: begin
        if (scl_rise) begin
          n.bits = r.bits + 4'h1;
        end
        if (scl_fall) begin
          if (r.bits == 4'h8) begin
            n.sda_oe = 1'b0;
            n.st = S_MACK;
          end else begin
            n.shr = {r.shr[6:0], 1'b0};
            n.sda_oe = ~r.shr[6];
          end
        end
      end
      S_MACK: begin
        if (scl_rise) begin
          n.mack = ~sda_h;
          if (!sda_h) begin
            n.ptr = r.ptr + 8'h01; // RULE_04
          end
        end
        if (scl_fall) begin
          if (r.mack) begin
            n.shr = loc_rdata;
            n.sda_oe = ~loc_rdata[7];
            n.bits = '0;
            n.st = S_RDATA;
          end else begin
            n.st = S_IGNORE;
          end
        end
      end
      S_IGNORE: begin
      end
      S_RELEASED: begin
        // Let our own release reach the synchronisers before judging
        n.settle = r.settle + 3'h1;
        if (r.settle == SETTLE_CYC) begin
          n.st = line_low ? S_SLEEP : S_IDLE; // RULE_09
        end
      end
      S_SLEEP: begin
        if (!line_low) begin
          n.st = S_IDLE;
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase

    if (r.st != S_RELEASED && r.st != S_SLEEP) begin
      if (start_c) begin
        n.st = S_ADDR;
        n.bits = '0;
        n.sda_oe = 1'b0;
      end else if (stop_c) begin
        n.st = S_IDLE;
        n.sda_oe = 1'b0;
      end
      // A moving line is traffic, not a stuck bus
      if (line_low && !line_move) begin
        n.low_cnt = r.low_cnt + 25'h0000001;
      end else begin
        n.low_cnt = '0;
      end
      if (line_low && !line_move && r.low_cnt == TIMEOUT_LAST) begin
        n.st = S_RELEASED; // RULE_08
        n.sda_oe = 1'b0;
        n.stretch = 1'b0;
        n.settle = '0;
        n.low_cnt = '0;
      end
    end
    n.sleep = (n.st == S_SLEEP); // RULE_09
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
      {r.scl_s, r.sda_s, r.scl_d, r.sda_d} <= '1; // Idle bus level, no false edge
      r.ptr <= PTR_RESET;
      r.cmd_gap <= WDOG_SAT;
    end else begin
      r <= n;
    end
  end

  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_scl_oe = r.stretch;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = r.sda_oe;
  assign loc_ptr = r.ptr;
  assign loc_wr_en = r.wr_en;
  assign loc_wr_addr = r.wr_addr;
  assign loc_wr_data = r.wr_data;
  assign bus_sleep = r.sleep;
  assign wdog_trip = r.wdog;
endmodule

// [verilog/gauge_i2c_master.sv]
// Host end: I2C master issuing gauge transfers with the required waits
`timescale 1ns/1ps
module gauge_i2c_master
  import gauge_i2c_pkg::*;
#(
  parameter int STRETCH_LIMIT_CYC = STRETCH_CYC,
  parameter int CHECKSUM_CYC = CHECKSUM_WAIT_CYC,
  parameter int STD_RW_CYC = STD_RW_WAIT_CYC,
  parameter int STD_RO_CYC = STD_SPACING_CYC,
  parameter int SUBCMD_CYC = SUBCMD_WAIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus
  gauge_i2c_if.host bus,
  // Transfer request
  input wire logic xfer_start,
  input wire op_t xfer_op,
  input wire logic [7:0] xfer_cmd,
  input wire logic [7:0] xfer_len,
  input wire wait_t xfer_wait,
  input wire logic [7:0] wr_byte,
  // Transfer results
  output logic busy,
  output logic wr_take,
  output logic [7:0] rd_byte,
  output logic rd_valid,
  output logic done,
  output logic nack_seen,
  output logic stretch_abort
);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(SCL_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] STR_LAST = CNT_W'(STRETCH_LIMIT_CYC - 1);

  typedef struct packed {
    host_state_t st;
    phase_t ph;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [3:0] bits;
    logic [7:0] shr;
    logic [CNT_W-1:0] tm;
    logic [CNT_W-1:0] str;
    logic [CNT_W-1:0] gap;
    logic [7:0] remain;
    op_t op;
    logic [7:0] cmd;
    logic scl_oe;
    logic sda_oe;
    logic busy;
    logic wr_take;
    logic [7:0] rd_byte;
    logic rd_valid;
    logic done;
    logic nack;
    logic abort;
  } host_regs_t;

  host_regs_t r;
  host_regs_t n;
  logic scl_h;
  logic sda_h;

  assign scl_h = r.scl_s[1];
  assign sda_h = r.sda_s[1];

  // Quiet time after the stop; never below the read-to-read gap
  function automatic logic [CNT_W-1:0] wait_cycles(input wait_t w);
    case (w)
      W_SUBCMD: wait_cycles = CNT_W'(SUBCMD_CYC); // RULE_10
      W_CHECKSUM: wait_cycles = CNT_W'(CHECKSUM_CYC); // RULE_11
      W_STD_RW: wait_cycles = CNT_W'(STD_RW_CYC); // RULE_12
      W_STD_RO: wait_cycles = CNT_W'(STD_RO_CYC); // RULE_13
      default: wait_cycles = CNT_W'(READ_GAP_CYC); // RULE_15
    endcase
  endfunction

  always_comb begin
    n = r;
    n.wr_take = 1'b0;
    n.rd_valid = 1'b0;
    n.done = 1'b0;
    n.scl_s = {r.scl_s[0], bus.scl};
    n.sda_s = {r.sda_s[0], bus.sda};
    case (r.st)
      H_IDLE: begin
        if (xfer_start) begin
          n.busy = 1'b1;
          n.nack = 1'b0;
          n.abort = 1'b0;
          n.op = xfer_op;
          n.cmd = xfer_cmd;
          n.remain = xfer_len;
          n.gap = wait_cycles(xfer_wait);
          n.ph = (xfer_op == OP_QUICK) ? PH_ADDRR : PH_ADDRW;
          n.shr = (xfer_op == OP_QUICK) ? ADDR_RD_BYTE : ADDR_WR_BYTE; // RULE_02
          n.sda_oe = 1'b1;
          n.st = H_START;
          n.tm = '0;
        end
      end
      H_START: begin
        n.tm = r.tm + 25'h0000001;
        if (r.tm == HALF_LAST) begin
          n.scl_oe = 1'b1;
          n.st = H_LOW;
          n.tm = '0;
          n.bits = '0;
        end
      end
      H_LOW: begin
        n.scl_oe = 1'b1;
        n.tm = r.tm + 25'h0000001;
        if (r.tm == DATA_HOLD_CYC) begin
          if (r.ph == PH_RDATA) begin
            n.sda_oe = (r.bits == 4'h8) && (r.remain != 8'h01);
          end else begin
            n.sda_oe = (r.bits != 4'h8) && !r.shr[7];
          end
        end
        if (r.tm == HALF_LAST) begin
          n.scl_oe = 1'b0;
          n.st = H_HIGH;
          n.tm = '0;
          n.str = '0;
        end
      end
      H_HIGH: begin
        if (!scl_h) begin
          // The target may hold SCL through a flash write
          n.str = r.str + 25'h0000001;
          if (r.str == STR_LAST) begin
            n.abort = 1'b1; // RULE_16
            n.st = H_STOP_A;
            n.tm = '0;
          end
        end else begin
          n.tm = r.tm + 25'h0000001;
          if (r.tm == HALF_LAST) begin
            n.scl_oe = 1'b1;
            n.st = H_LOW;
            n.tm = '0;
            n.bits = r.bits + 4'h1;
            if (r.bits != 4'h8) begin
              n.shr = {r.shr[6:0], sda_h};
            end else begin
              n.bits = '0;
              if (sda_h && r.ph != PH_RDATA) begin
                n.nack = 1'b1;
                n.st = H_STOP_A;
              end else begin
                case (r.ph)
                  PH_ADDRW: begin
                    n.ph = PH_CMD;
                    n.shr = r.cmd;
                  end
                  PH_CMD: begin
                    if (r.op != OP_WRITE) begin
                      n.st = H_RS_A;
                    end else if (r.remain == 8'h00) begin
                      n.st = H_STOP_A;
                    end else begin
                      n.ph = PH_WDATA;
                      n.shr = wr_byte;
                      n.wr_take = 1'b1;
                    end
                  end
                  PH_WDATA: begin
                    n.remain = r.remain - 8'h01;
                    if (r.remain == 8'h01) begin
                      n.st = H_STOP_A;
                    end else begin
                      n.shr = wr_byte;
                      n.wr_take = 1'b1;
                    end
                  end
                  PH_ADDRR: begin
                    if (r.remain == 8'h00) begin
                      n.st = H_STOP_A;
                    end else begin
                      n.ph = PH_RDATA;
                    end
                  end
                  default: begin
                    n.rd_byte = r.shr;
                    n.rd_valid = 1'b1;
                    n.remain = r.remain - 8'h01;
                    if (r.remain == 8'h01) begin
                      n.st = H_STOP_A;
                    end
                  end
                endcase
              end
            end
          end
        end
      end
      H_RS_A: begin
        n.scl_oe = 1'b1;
        n.tm = r.tm + 25'h0000001;
        if (r.tm == DATA_HOLD_CYC) begin
          n.sda_oe = 1'b0;
        end
        if (r.tm == HALF_LAST) begin
          n.scl_oe = 1'b0;
          n.st = H_RS_B;
          n.tm = '0;
        end
      end
      H_RS_B: begin
        if (scl_h) begin
          n.tm = r.tm + 25'h0000001;
          if (r.tm == HALF_LAST) begin
            n.sda_oe = 1'b1;
            n.st = H_START;
            n.tm = '0;
            n.ph = PH_ADDRR;
            n.shr = ADDR_RD_BYTE; // RULE_02
          end
        end
      end
      H_STOP_A: begin
        n.scl_oe = 1'b1;
        n.tm = r.tm + 25'h0000001;
        if (r.tm == DATA_HOLD_CYC) begin
          n.sda_oe = 1'b1;
        end
        if (r.tm == HALF_LAST) begin
          n.scl_oe = 1'b0;
          n.st = H_STOP_B;
          n.tm = '0;
        end
      end
      H_STOP_B: begin
        if (scl_h) begin
          n.tm = r.tm + 25'h0000001;
          if (r.tm == HALF_LAST) begin
            n.sda_oe = 1'b0;
            n.st = H_GAP;
            n.tm = '0;
          end
        end
      end
      H_GAP: begin
        n.tm = r.tm + 25'h0000001;
        if (r.tm == r.gap - 25'h0000001) begin
          n.busy = 1'b0; // RULE_15
          n.done = 1'b1;
          n.st = H_IDLE;
        end
      end
      default: begin
        n.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = r.scl_oe;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = r.sda_oe;
  assign busy = r.busy;
  assign wr_take = r.wr_take;
  assign rd_byte = r.rd_byte;
  assign rd_valid = r.rd_valid;
  assign done = r.done;
  assign nack_seen = r.nack;
  assign stretch_abort = r.abort;
endmodule

// [testbench/gauge_i2c_props.sv]
// Wire-level checker for the gauge I2C link
`timescale 1ns/1ps
module gauge_i2c_props
  import gauge_i2c_pkg::*;
#(
  parameter int STRETCH_MAX_CYC = 300,
  parameter int TIMEOUT_CYC = 2000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Target wires
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  // Master wires
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  // Resolved lines
  input wire logic scl,
  input wire logic sda
);
  logic scl_ff, sda_ff, in_xfer_ff;
  logic [15:0] stretch_ff, stuck_ff, gap_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  // Margins cover the two-flop synchronisers
  always_ff @(posedge clk) begin
    scl_ff <= scl;
    sda_ff <= sda;
    if (!nrst) begin
      in_xfer_ff <= 1'b0;
      stretch_ff <= 16'h0000;
      stuck_ff <= 16'h0000;
      gap_ff <= 16'hFFFF;
    end else begin
      if (scl && scl_ff && sda_ff && !sda) in_xfer_ff <= 1'b1;
      else if (scl && scl_ff && !sda_ff && sda) in_xfer_ff <= 1'b0;
      stretch_ff <= dev_scl_oe ? stretch_ff + 16'h0001 : 16'h0000;
      stuck_ff <= ((scl && sda) || scl != scl_ff || sda != sda_ff) ? 16'h0000 : stuck_ff + 16'h0001;
      if (scl && scl_ff && !sda_ff && sda) gap_ff <= 16'h0000;
      else if (gap_ff != 16'hFFFF) gap_ff <= gap_ff + 16'h0001;
    end
  end
  a_open_drain_zero: assert property (!dev_scl_o && !dev_sda_o && !host_scl_o && !host_sda_o)
    else $error("an output value is not low");
  a_bus_idle_reset: assert property ($rose(nrst) |-> !(dev_scl_oe || dev_sda_oe || host_scl_oe || host_sda_oe))
    else $error("line driven at reset release");
  a_idle_no_drive: assert property (!in_xfer_ff |-> !dev_sda_oe && !dev_scl_oe)
    else $error("target drives outside a transfer");
  a_sda_hold_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("target moved sda while scl high");
  a_drive_after_fall: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
    else $error("target sda change not after scl fall");
  a_stretch_bound: assert property (stretch_ff <= 16'(STRETCH_MAX_CYC + 4))
    else $error("clock stretch too long");
  a_timeout_release: assert property (stuck_ff >= 16'(TIMEOUT_CYC + 12) |-> !dev_sda_oe && !dev_scl_oe)
    else $error("lines not released after stuck bus");
  a_read_gap: assert property (s_start |-> gap_ff >= 16'(READ_GAP_CYC - 2))
    else $error("start too soon after stop");
endmodule

// [testbench/gauge_i2c_slave_port_tb_top.sv]
// Self-checking bench joining the gauge target and master
`timescale 1ns/1ps
module gauge_i2c_slave_port_tb_top import gauge_i2c_pkg::*;;
  logic clk, nrst, xfer_start, flash_busy, busy, wr_take, rd_valid, done, nack_seen;
  logic stretch_abort, loc_wr_en, bus_sleep, wdog_trip, loc_read_only;
  op_t xfer_op;
  wait_t xfer_wait;
  logic [7:0] xfer_cmd, xfer_len, wr_byte, rd_byte, loc_ptr, loc_wr_addr, loc_wr_data, loc_rdata;
  logic [7:0] mem [256];
  logic [7:0] wq[$], rq[$], aq[$], dq[$];
  int exp_mem [256];
  int n_mismatch = 0, n_compared = 0, n_cyc = 0, n_trip = 0, n_x = 0, widx = 0, cur_p = 0;
  int seed, n;
  gauge_i2c_if bus ();
  // Locations 08..0F are read-only
  assign loc_rdata = mem[loc_ptr];
  assign loc_read_only = loc_ptr inside {[8'h08:8'h0F]};
  gauge_i2c_target #(.TIMEOUT_CYC(2000), .STRETCH_MAX_CYC(300))
    i_gauge_i2c_target (.clk(clk), .nrst(nrst), .bus(bus.dev), .loc_rdata(loc_rdata),
    .loc_read_only(loc_read_only), .flash_busy(flash_busy), .loc_ptr(loc_ptr),
    .loc_wr_en(loc_wr_en), .loc_wr_addr(loc_wr_addr), .loc_wr_data(loc_wr_data),
    .bus_sleep(bus_sleep), .wdog_trip(wdog_trip));
  gauge_i2c_master #(.CHECKSUM_CYC(900), .STD_RW_CYC(800), .STD_RO_CYC(700))
    i_gauge_i2c_master (.clk(clk), .nrst(nrst),
    .bus(bus.host), .xfer_start(xfer_start), .xfer_op(xfer_op), .xfer_cmd(xfer_cmd),
    .xfer_len(xfer_len), .xfer_wait(xfer_wait), .wr_byte(wr_byte), .busy(busy),
    .wr_take(wr_take), .rd_byte(rd_byte), .rd_valid(rd_valid), .done(done),
    .nack_seen(nack_seen), .stretch_abort(stretch_abort));
  gauge_i2c_props i_gauge_i2c_props (.clk(clk),
    .nrst(nrst), .dev_scl_o(bus.dev_scl_o), .dev_scl_oe(bus.dev_scl_oe),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .host_scl_o(bus.host_scl_o),
    .host_scl_oe(bus.host_scl_oe), .host_sda_o(bus.host_sda_o),
    .host_sda_oe(bus.host_sda_oe), .scl(bus.scl), .sda(bus.sda));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Capture results; hand the master its next write byte
  always @(posedge clk) begin
    n_cyc <= n_cyc + 1;
    if (rd_valid === 1'b1) rq.push_back(rd_byte);
    if (loc_wr_en === 1'b1) begin
      aq.push_back(loc_wr_addr);
      dq.push_back(loc_wr_data);
      mem[loc_wr_addr] <= loc_wr_data;
    end
    if (wdog_trip === 1'b1) n_trip++;
    if (wr_take === 1'b1) begin
      widx <= widx + 1;
      wr_byte <= (widx + 1 < wq.size()) ? wq[widx+1] : 8'h00;
    end
    if (n_cyc == 90000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic cmpb(input logic e, input logic g);
    cmp({7'h00, e}, {7'h00, g});
  endtask
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Wait choice cycles through every wait kind
  task automatic xfer(input op_t op, input logic [7:0] cmd, input int len);
    int k;
    rq.delete();
    aq.delete();
    dq.delete();
    @(posedge clk);
    xfer_start <= 1'b1;
    xfer_op <= op;
    xfer_cmd <= cmd;
    xfer_len <= 8'(len);
    xfer_wait <= wait_t'(n_x % 5);
    widx <= 0;
    wr_byte <= (wq.size() > 0) ? wq[0] : 8'h00;
    n_x++;
    @(posedge clk);
    xfer_start <= 1'b0;
    @(negedge clk);
    cmpb(1'b1, busy);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1 && k < 20000);
    if (k >= 20000) n_mismatch++;
    cmpb(1'b0, busy);
  endtask
  task automatic do_write(input logic [7:0] cmd, input int len);
    int p;
    p = cmd;
    wq.delete();
    for (int i = 0; i < len; i++) wq.push_back(8'($urandom));
    xfer(OP_WRITE, cmd, len);
    cmp(8'(len), 8'(aq.size()));
    foreach (wq[i]) begin
      cmp(8'(p), aq[i]);
      cmp(wq[i], dq[i]);
      exp_mem[p] = wq[i];
      p++;
    end
    cmp(8'(p), loc_ptr);
    cmpb(1'b0, nack_seen);
    cur_p = p;
  endtask
  task automatic do_read(input op_t op, input logic [7:0] cmd, input int len);
    int p;
    p = (op == OP_QUICK) ? cur_p : cmd;
    wq.delete();
    xfer(op, cmd, len);
    cmp(8'(len), 8'(rq.size()));
    for (int i = 0; i < len; i++) begin
      cmp(8'(exp_mem[p]), rq[i]);
      if (i < len - 1) p++;
    end
    cmp(8'(p), loc_ptr);
    cur_p = p;
  endtask
  task automatic do_refused(input logic [7:0] cmd);
    wq = {8'($urandom), 8'($urandom)};
    xfer(OP_WRITE, cmd, 2);
    cmpb(1'b1, nack_seen);
    cmp(8'h00, 8'(aq.size()));
  endtask
  initial begin
    nrst = 1'b0;
    xfer_start = 1'b0;
    xfer_op = OP_READ;
    xfer_cmd = 8'h00;
    xfer_len = 8'h00;
    xfer_wait = W_NONE;
    wr_byte = 8'h00;
    flash_busy = 1'b0;
    bus.ext_scl_hold = 1'b0;
    bus.ext_sda_hold = 1'b0;
    seed = $urandom(32'hE5EC14BA);
    for (int a = 0; a < 256; a++) begin
      mem[a] = 8'($urandom);
      exp_mem[a] = mem[a];
    end
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    do_write(8'h20, 3);
    do_write(8'h6B, 1);
    $display("Writes finished");
    do_read(OP_READ, 8'h20, 3);
    do_read(OP_QUICK, 8'h00, 2);
    $display("Reads finished");
    do_refused(8'h08);
    cmp(8'h08, loc_ptr);
    do_refused(8'h6C);
    do_refused(8'hFF);
    do_read(OP_READ, 8'h00, 1);
    do_read(OP_QUICK, 8'h00, 3);
    $display("Refusals finished");
    // Stretch shorter than the target limit, master must wait it out
    @(posedge clk);
    flash_busy <= 1'b1;
    fork
      do_write(8'h30, 2);
      begin
        n = 0;
        while (bus.dev_scl_oe !== 1'b1 && n < 5000) begin
          @(negedge clk);
          n++;
        end
        repeat (150) @(posedge clk);
        flash_busy <= 1'b0;
      end
    join
    cmpb(1'b1, n < 5000);
    cmpb(1'b0, stretch_abort);
    $display("Stretch finished");
    @(posedge clk);
    bus.ext_scl_hold <= 1'b1;
    repeat (2100) @(posedge clk);
    @(negedge clk);
    cmpb(1'b1, bus_sleep);
    @(posedge clk);
    bus.ext_scl_hold <= 1'b0;
    repeat (40) @(posedge clk);
    @(negedge clk);
    cmpb(1'b0, bus_sleep);
    do_read(OP_READ, 8'h21, 2);
    $display("Stuck bus finished");
    // Second reset: command gap comes back saturated, so the first command cannot trip and only the second may
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    n_trip = 0;
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    do_write(8'h40, 1);
    cmp(8'h00, 8'(n_trip));
    do_write(8'h41, 1);
    cmp(8'h01, 8'(n_trip));
    $display("Rate finished");
    close_out();
  end
endmodule
